// [rtl/wsc_top.sv]
// Contract
// - Watchdog counts on its own free-running oscillator ticks, also in sleep.
// - Watchdog time-out while running requests a full device reset.
// - Watchdog time-out in sleep wakes the core without reset.
// - Every watchdog time-out clears the time-out flag.
// - Config watchdog enable cleared disables watchdog reset and wake entirely.
// - One scaler shared by timer0 and watchdog, chosen by option bits.
// - Clear-watchdog and sleep clear counter, and scaler when watchdog owns it.
// - Clearing the scaler leaves assignment and ratio bits unchanged.
// - Sleep entry clears watchdog, clears power-down, sets time-out, stops oscillator.
// - Pins hold their drive state throughout sleep.
// - Reset pin in sleep resets; watchdog or interrupt wake resumes execution.
// - Power-down flag set at power-up, cleared by sleep; time-out wake clears time-out.
// - Only listed asynchronous peripheral interrupts can wake; clocked ones cannot.
// - Sleep prefetches the instruction at the next address.
// - Interrupt wake needs the source enable, regardless of global enable.
// - Global enable off continues in line; on executes next then vectors.
// - Sleep with an enabled flag already set acts as a no-operation.
// - Interrupt during or after sleep: sleep completes fully, then immediate wake.
// - Crystal modes wait 1024 oscillator periods after wake; RC mode skips it.
// - Global enable gates vectoring; flags set regardless.
//
// Local design decision: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "wsc_cfg.svh"

module wsc_top #(
	parameter logic [7:0] WDT_BASE_TICKS = `WSC_WDT_BASE_TICKS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] config_word_in,
	input wire logic wdt_osc_tick,
	input wire logic tmr0_tick_in,
	input wire logic clear_watchdog_instr,
	input wire logic sleep_instr,
	input wire logic [10:0] irq_event,
	input wire logic external_reset_pin_n,
	output logic tmr0_inc,
	output logic device_reset,
	output logic main_osc_enable,
	output logic io_hold,
	output logic prefetch_next,
	output logic resume,
	output logic branch_to_vector,
	output logic irq_vector_req,
	output logic timeout_flag,
	output logic powerdown_flag
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	// Scaler tap mask: 2^(ratio+extra) counts per output pulse
	function automatic logic [7:0] ratio_mask(input logic [2:0] ratio, input logic extra);
		logic [8:0] wide;
		wide = (9'h001 << ({6'h00, ratio} + {8'h00, extra})) - 9'h001;
		return wide[7:0];
	endfunction

	// True for every address that the slave answers
	function automatic logic addr_hit(input logic [15:0] a);
		logic hit;
		hit = 1'b0;
		if (a == `WSC_ADDR_CONFIG) begin
			hit = 1'b1;
		end else if (a == `WSC_ADDR_OPTION || a == `WSC_ADDR_OPTION_HI) begin
			hit = 1'b1;
		end else if (a == `WSC_ADDR_STATUS || a == `WSC_ADDR_IRQ_CTRL) begin
			hit = 1'b1;
		end else if (a == `WSC_ADDR_IRQ_FLAGS || a == `WSC_ADDR_STATE) begin
			hit = 1'b1;
		end
		return hit;
	endfunction

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	localparam logic [10:0] OST_CYCLES = 11'(`WSC_OST_CYCLES);

	wsc_pkg::wsc_state_type state;
	wsc_pkg::wsc_option_type option_control;
	wsc_pkg::wsc_flags_type flags;
	logic [7:0] config_word;
	logic cfg_loaded;
	logic [7:0] watchdog_counter;
	logic [7:0] scaler;
	logic [10:0] ost_count;
	logic [10:0] irq_enable;
	logic [10:0] irq_flags;
	logic global_irq_enable;
	logic woke_by_irq;
	logic wdt_enabled;
	logic crystal_mode;
	logic wdt_base;
	logic timeout_evt;
	logic pending_irq;
	logic sleep_enter;
	logic clear_wdt;
	logic wake_evt;
	logic ext_reset;
	logic wdt_reset;
	logic apb_wr;
	logic [7:0] opt_mask;
	logic [10:0] next_irq_flags;
	logic [10:0] flag_gate;

	// ----------------------------------------------------------------
	// Decoded conditions
	// ----------------------------------------------------------------
	assign wdt_enabled = cfg_loaded & config_word[`WSC_CFG_WDT_EN_BIT];
	assign crystal_mode = config_word[`WSC_CFG_OSC_LSB +: 2] != `WSC_OSC_RC_CODE;
	assign pending_irq = |(irq_flags & irq_enable);
	assign ext_reset = ~external_reset_pin_n;
	assign sleep_enter = sleep_instr & (state == wsc_pkg::WSC_RUN) & ~pending_irq;
	assign clear_wdt = (clear_watchdog_instr & (state == wsc_pkg::WSC_RUN)) | sleep_enter;
	assign wdt_base = wdt_enabled & wdt_osc_tick & (watchdog_counter == WDT_BASE_TICKS);
	assign opt_mask = ratio_mask(option_control.scaler_ratio, ~option_control.scaler_assign);
	assign wake_evt = (state == wsc_pkg::WSC_SLEEP) & (timeout_evt | pending_irq);
	// Oscillator wait still counts as asleep, so a time-out there never resets
	assign wdt_reset = timeout_evt & (state == wsc_pkg::WSC_RUN);
	assign apb_wr = psel & penable & pwrite;

	// Scaler output toward the watchdog when assigned to it, else direct
	always_comb begin
		timeout_evt = 1'b0;
		tmr0_inc = 1'b0;
		if (option_control.scaler_assign) begin
			timeout_evt = wdt_base & ((scaler & opt_mask) == opt_mask);
			tmr0_inc = tmr0_tick_in;
		end else begin
			timeout_evt = wdt_base;
			tmr0_inc = tmr0_tick_in & ((scaler & opt_mask) == opt_mask);
		end
		if (clear_wdt) begin
			timeout_evt = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Nonvolatile configuration, caught once after reset release
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			config_word <= 8'h00;
			cfg_loaded <= 1'b0;
		end else if (!cfg_loaded) begin
			config_word <= config_word_in;
			cfg_loaded <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Watchdog base counter on the free-running oscillator ticks
	// ----------------------------------------------------------------
	// Ticks keep arriving while the main clock is gated, so sleep still times out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			watchdog_counter <= 8'h00;
		end else if (!wdt_enabled || clear_wdt || device_reset) begin
			watchdog_counter <= 8'h00;
		end else if (wdt_osc_tick) begin
			if (watchdog_counter == WDT_BASE_TICKS) begin
				watchdog_counter <= 8'h00;
			end else begin
				watchdog_counter <= watchdog_counter + 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// Shared scaler
	// ----------------------------------------------------------------
	// On clear-watchdog or sleep the count is cleared only while the watchdog owns the scaler; the option bits stay as software set them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scaler <= 8'h00;
		end else if (device_reset) begin
			scaler <= 8'h00;
		end else if (clear_wdt && option_control.scaler_assign) begin
			scaler <= 8'h00;
		end else if (option_control.scaler_assign && wdt_base) begin
			scaler <= scaler + 8'h01;
		end else if (!option_control.scaler_assign && tmr0_tick_in) begin
			scaler <= scaler + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// Option register
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			option_control <= `WSC_OPTION_RST;
		end else if (device_reset) begin
			option_control <= `WSC_OPTION_RST;
		end else if (apb_wr && (paddr == `WSC_ADDR_OPTION || paddr == `WSC_ADDR_OPTION_HI)) begin
			option_control <= pwdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// Interrupt enables and flags
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_enable <= 11'h000;
			global_irq_enable <= 1'b0;
		end else if (device_reset) begin
			irq_enable <= 11'h000;
			global_irq_enable <= 1'b0;
		end else if (apb_wr && paddr == `WSC_ADDR_IRQ_CTRL) begin
			irq_enable <= pwdata[10:0];
			global_irq_enable <= pwdata[`WSC_GLOBAL_EN_BIT];
		end
	end

	// No on-chip clocks in sleep: clocked sources cannot raise a flag there
	always_comb begin
		flag_gate = (state == wsc_pkg::WSC_RUN) ? 11'h7ff : `WSC_WAKE_CAPABLE;
		next_irq_flags = irq_flags;
		if (apb_wr && paddr == `WSC_ADDR_IRQ_FLAGS) begin
			next_irq_flags = irq_flags & ~pwdata[10:0];
		end
		// Set wins over a same-cycle clear; enables do not gate the flag
		next_irq_flags = next_irq_flags | (irq_event & flag_gate);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_flags <= 11'h000;
		end else if (device_reset) begin
			irq_flags <= 11'h000;
		end else begin
			irq_flags <= next_irq_flags;
		end
	end

	// Vectoring is held off while asleep or waiting for the oscillator
	assign irq_vector_req = global_irq_enable & pending_irq & (state == wsc_pkg::WSC_RUN);

	// ----------------------------------------------------------------
	// Time-out and power-down flags
	// ----------------------------------------------------------------
	// Flags survive pin and watchdog resets so software can tell the cause
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags <= 2'b11;
		end else if (timeout_evt) begin
			flags.timeout_flag <= 1'b0;
		end else if (sleep_enter) begin
			flags.timeout_flag <= 1'b1;
			flags.powerdown_flag <= 1'b0;
		end
	end

	assign timeout_flag = flags.timeout_flag;
	assign powerdown_flag = flags.powerdown_flag;

	// ----------------------------------------------------------------
	// Power state machine
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= wsc_pkg::WSC_RUN;
			ost_count <= 11'h000;
			woke_by_irq <= 1'b0;
		end else if (ext_reset || device_reset) begin
			state <= wsc_pkg::WSC_RUN;
			ost_count <= 11'h000;
			woke_by_irq <= 1'b0;
		end else begin
			case (state)
				wsc_pkg::WSC_RUN: begin
					if (sleep_enter) begin
						state <= wsc_pkg::WSC_SLEEP;
					end
				end
				wsc_pkg::WSC_SLEEP: begin
					if (wake_evt) begin
						woke_by_irq <= ~timeout_evt;
						ost_count <= OST_CYCLES - 11'h001;
						state <= crystal_mode ? wsc_pkg::WSC_OSC_WAIT : wsc_pkg::WSC_RUN;
					end
				end
				wsc_pkg::WSC_OSC_WAIT: begin
					if (ost_count == 11'h000) begin
						state <= wsc_pkg::WSC_RUN;
					end else begin
						ost_count <= ost_count - 11'h001;
					end
				end
				default: begin
					state <= wsc_pkg::WSC_RUN;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Core-facing strobes, all from flops
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			device_reset <= 1'b0;
			prefetch_next <= 1'b0;
			resume <= 1'b0;
			branch_to_vector <= 1'b0;
		end else begin
			device_reset <= ext_reset | wdt_reset;
			prefetch_next <= sleep_enter;
			resume <= 1'b0;
			branch_to_vector <= 1'b0;
			if (!ext_reset && !device_reset) begin
				if ((state == wsc_pkg::WSC_SLEEP && wake_evt && !crystal_mode) ||
					(state == wsc_pkg::WSC_OSC_WAIT && ost_count == 11'h000)) begin
					resume <= 1'b1;
					// Branch only after the prefetched word has run
					branch_to_vector <= global_irq_enable &
						(state == wsc_pkg::WSC_SLEEP ? ~timeout_evt : woke_by_irq);
				end
			end
		end
	end

	// Oscillator gated and pin state frozen from sleep entry to resume
	assign main_osc_enable = (state == wsc_pkg::WSC_RUN);
	assign io_hold = (state != wsc_pkg::WSC_RUN);

	// ----------------------------------------------------------------
	// APB slave: zero wait, read data captured in the setup cycle
	// ----------------------------------------------------------------
	assign pready = psel & penable;
	assign pslverr = psel & penable & ~addr_hit(paddr);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= 32'h0000_0000;
			if (paddr == `WSC_ADDR_CONFIG) begin
				prdata[7:0] <= config_word;
			end else if (paddr == `WSC_ADDR_OPTION || paddr == `WSC_ADDR_OPTION_HI) begin
				prdata[7:0] <= option_control;
			end else if (paddr == `WSC_ADDR_STATUS) begin
				prdata[`WSC_ST_TIMEOUT_BIT] <= flags.timeout_flag;
				prdata[`WSC_ST_POWERDOWN_BIT] <= flags.powerdown_flag;
			end else if (paddr == `WSC_ADDR_IRQ_CTRL) begin
				prdata[10:0] <= irq_enable;
				prdata[`WSC_GLOBAL_EN_BIT] <= global_irq_enable;
			end else if (paddr == `WSC_ADDR_IRQ_FLAGS) begin
				prdata[10:0] <= irq_flags;
			end else if (paddr == `WSC_ADDR_STATE) begin
				prdata[1:0] <= state;
				prdata[15:8] <= watchdog_counter;
				prdata[23:16] <= scaler;
			end
		end
	end

endmodule

`default_nettype wire

// [rtl/wsc_cfg.svh]
`ifndef WSC_CFG_SVH
`define WSC_CFG_SVH

// ----------------------------------------------------------------
// Register map (byte addresses on APB)
// ----------------------------------------------------------------
`define WSC_IDX_CONFIG 16'h2007
`define WSC_IDX_OPTION 16'h0081
`define WSC_IDX_OPTION_HI 16'h0181
`define WSC_ADDR_CONFIG 16'h801c
`define WSC_ADDR_OPTION 16'h0204
`define WSC_ADDR_OPTION_HI 16'h0604
`define WSC_ADDR_STATUS 16'h0000
`define WSC_ADDR_IRQ_CTRL 16'h0008
`define WSC_ADDR_IRQ_FLAGS 16'h000c
`define WSC_ADDR_STATE 16'h0010

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WSC_CFG_WDT_EN_BIT 2
`define WSC_CFG_OSC_LSB 0
`define WSC_OPT_ASSIGN_BIT 3
`define WSC_OPT_RATIO_LSB 0
`define WSC_ST_TIMEOUT_BIT 4
`define WSC_ST_POWERDOWN_BIT 3
`define WSC_GLOBAL_EN_BIT 15
`define WSC_IRQ_N 11

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define WSC_OPTION_RST 8'hff
`define WSC_OSC_RC_CODE 2'h3
`define WSC_WAKE_CAPABLE 11'h7fc
`define WSC_WDT_BASE_TICKS 8'hff

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define WSC_PCLK_PERIOD_NS 50
`define WSC_TOSC_NS 50
`define WSC_OST_OSC_PERIODS 1024
`define WSC_OST_CYCLES \
	((`WSC_OST_OSC_PERIODS * `WSC_TOSC_NS + `WSC_PCLK_PERIOD_NS - 1) / `WSC_PCLK_PERIOD_NS)

`endif

// [rtl/wsc_pkg.sv]
`default_nettype none

package wsc_pkg;

	// Power state of the core as seen by this block
	typedef enum logic [1:0] {
		WSC_RUN,
		WSC_SLEEP,
		WSC_OSC_WAIT
	} wsc_state_type;

	// Shared scaler setup held in the option register
	typedef struct packed {
		logic [3:0] other;
		logic scaler_assign;
		logic [2:0] scaler_ratio;
	} wsc_option_type;

	// Processor status flags owned by this block
	typedef struct packed {
		logic timeout_flag;
		logic powerdown_flag;
	} wsc_flags_type;

endpackage

`default_nettype wire

// [dv/wsc_top_properties.sv]
`timescale 1ns/10ps
`default_nettype none
`include "wsc_cfg.svh"

module wsc_top_properties #(
	parameter logic [7:0] WDT_BASE_TICKS = `WSC_WDT_BASE_TICKS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] config_word_in,
	input wire logic sleep_instr,
	input wire logic external_reset_pin_n,
	input wire logic device_reset,
	input wire logic main_osc_enable,
	input wire logic io_hold,
	input wire logic prefetch_next,
	input wire logic resume,
	input wire logic branch_to_vector,
	input wire logic irq_vector_req,
	input wire logic timeout_flag,
	input wire logic powerdown_flag
);
	// ----------------------------------------------------------------
	// Power state checks, all on the bus clock
	// ----------------------------------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_SLEEP_ENTRY: assert property ($rose(io_hold) |-> $past(sleep_instr) && prefetch_next
		&& !powerdown_flag && timeout_flag) else $error("sleep entry state wrong");
	AST_PREFETCH: assert property (prefetch_next |-> io_hold && $past(sleep_instr))
		else $error("prefetch without sleep");
	AST_HOLD_PINS: assert property ($fell(io_hold) |-> resume || device_reset
		|| $past(device_reset)) else $error("pin hold released without wake or reset");
	AST_PIN_RESET: assert property (!external_reset_pin_n |=> device_reset)
		else $error("reset pin ignored");
	AST_RESUME_CLEAN: assert property (resume |-> !device_reset ##[0:1] main_osc_enable)
		else $error("wake did not resume cleanly");
	AST_BRANCH: assert property (branch_to_vector |-> resume)
		else $error("branch outside resume");
	AST_TO_FALL: assert property ($fell(timeout_flag) |-> config_word_in[2])
		else $error("time-out with watchdog disabled");
	AST_PD_HOLD: assert property (!$rose(powerdown_flag))
		else $error("power-down flag set outside power-up");
	AST_VEC_RUN: assert property (irq_vector_req |-> main_osc_enable)
		else $error("vector request while stopped");
	AST_NOWDT_RESET: assert property (device_reset && !config_word_in[2] |->
		!$past(external_reset_pin_n) || !$past(external_reset_pin_n, 2))
		else $error("reset from disabled watchdog");

	// Main scenarios seen
	COV_SLEEP: cover property ($rose(io_hold));
	COV_BRANCH: cover property (resume && branch_to_vector);
	COV_RESET: cover property (device_reset);
endmodule

bind wsc_top wsc_top_properties #(.WDT_BASE_TICKS(WDT_BASE_TICKS)) u_props (
	.pclk(pclk), .presetn(presetn), .config_word_in(config_word_in),
	.sleep_instr(sleep_instr), .external_reset_pin_n(external_reset_pin_n),
	.device_reset(device_reset), .main_osc_enable(main_osc_enable), .io_hold(io_hold),
	.prefetch_next(prefetch_next), .resume(resume), .branch_to_vector(branch_to_vector),
	.irq_vector_req(irq_vector_req), .timeout_flag(timeout_flag),
	.powerdown_flag(powerdown_flag)
);
`default_nettype wire

// [dv/wsc_top_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "wsc_cfg.svh"

module wsc_top_tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, last_branch;
	logic [7:0] config_word_in = 8'h07;
	logic wdt_osc_tick = 1'b0, tmr0_tick_in = 1'b0, clear_watchdog_instr = 1'b0;
	logic sleep_instr = 1'b0, external_reset_pin_n = 1'b1, wdt_run = 1'b0;
	logic [10:0] irq_event = 11'h000;
	logic tmr0_inc, device_reset, main_osc_enable, io_hold, prefetch_next, resume;
	logic branch_to_vector, irq_vector_req, timeout_flag, powerdown_flag;
	int mismatches = 0, checks = 0, resets = 0, resumes = 0, incs = 0, n, r, r0, src;

	// Short base period keeps every time-out within a few dozen cycles
	wsc_top #(.WDT_BASE_TICKS(8'h03)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.config_word_in(config_word_in), .wdt_osc_tick(wdt_osc_tick),
		.tmr0_tick_in(tmr0_tick_in), .clear_watchdog_instr(clear_watchdog_instr),
		.sleep_instr(sleep_instr), .irq_event(irq_event),
		.external_reset_pin_n(external_reset_pin_n), .tmr0_inc(tmr0_inc),
		.device_reset(device_reset), .main_osc_enable(main_osc_enable), .io_hold(io_hold),
		.prefetch_next(prefetch_next), .resume(resume), .branch_to_vector(branch_to_vector),
		.irq_vector_req(irq_vector_req), .timeout_flag(timeout_flag),
		.powerdown_flag(powerdown_flag)
	);

	// ----------------------------------------------------------------
	// Clock, free-running watchdog oscillator and event counters
	// ----------------------------------------------------------------
	always #25 pclk = ~pclk;

	// Oscillator keeps ticking in sleep, one pulse every second cycle
	always @(posedge pclk) wdt_osc_tick <= wdt_run & ~wdt_osc_tick;

	// Counters let waits see a pulse however short it is
	always @(posedge pclk) begin
		if (device_reset === 1'b1)
			resets <= resets + 1;
		if (resume === 1'b1)
			resumes <= resumes + 1;
		if (resume === 1'b1)
			last_branch <= branch_to_vector;
		if (tmr0_inc === 1'b1)
			incs <= incs + 1;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	function automatic logic [31:0] st(input logic timeout_bit, input logic powerdown_bit);
		return {27'h0, timeout_bit, powerdown_bit, 3'h0};
	endfunction

	function automatic int tmr_exp(input int ticks, input int ratio);
		return ticks >> (ratio + 1);
	endfunction

	task automatic chk(input logic [31:0] s, input logic [31:0] x, input string m);
		checks++;
		if (s !== x) begin
			mismatches++;
			$display("MISMATCH t=%0t %s seen %h expected %h", $time, m, s, x);
		end
	endtask

	// Waits for pready however long it takes; only the hang guard ends a stuck wait
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [15:0] a, input logic [31:0] x, input string m);
		apb(1'b0, a, 32'h0);
		chk(rd, x, m);
	endtask

	// Software clears the watchdog in the cycle right before sleep
	task automatic pulse_sleep;
		@(posedge pclk) clear_watchdog_instr <= 1'b1;
		@(posedge pclk) clear_watchdog_instr <= 1'b0;
		sleep_instr <= 1'b1;
		@(posedge pclk) sleep_instr <= 1'b0;
		@(negedge pclk);
	endtask

	task automatic pirq(input int b);
		@(posedge pclk) irq_event <= 11'h001 << b;
		@(posedge pclk) irq_event <= 11'h000;
	endtask

	task automatic waitc(input logic on_reset, input int lim, output int cnt);
		int c0;
		c0 = on_reset ? resets : resumes;
		cnt = 0;
		while ((on_reset ? resets : resumes) == c0 && cnt < lim) begin
			@(posedge pclk);
			cnt++;
		end
	endtask

	// Config is only changed while the part is held in power-up reset
	task automatic do_reset(input logic [7:0] cfg);
		@(posedge pclk) presetn <= 1'b0;
		config_word_in <= cfg;
		wdt_run <= 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(49));
		do_reset(8'h07);
		rdchk(`WSC_ADDR_STATUS, st(1'b1, 1'b1), "power-up flags");
		rdchk(`WSC_ADDR_OPTION, 32'hff, "option reset");
		apb(1'b1, `WSC_ADDR_CONFIG, 32'h0);
		rdchk(`WSC_ADDR_CONFIG, 32'h07, "config read-only");
		apb(1'b0, 16'h0100, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped error");
		r = $urandom_range(2, 0);
		apb(1'b1, `WSC_ADDR_OPTION, 32'(r));
		repeat (3 << (r + 1)) begin
			@(posedge pclk) tmr0_tick_in <= 1'b1;
			@(posedge pclk) tmr0_tick_in <= 1'b0;
		end
		@(posedge pclk);
		chk(32'(incs), 32'(tmr_exp(3 << (r + 1), r)), "timer prescale");
		r = $urandom_range(255, 0) | 8;
		apb(1'b1, `WSC_ADDR_OPTION_HI, 32'(r));
		rdchk(`WSC_ADDR_OPTION, 32'(r), "option alias");
		@(posedge pclk) clear_watchdog_instr <= 1'b1;
		@(posedge pclk) clear_watchdog_instr <= 1'b0;
		rdchk(`WSC_ADDR_OPTION, 32'(r), "option kept by clear");
		// Clearing faster than the period holds off the reset
		apb(1'b1, `WSC_ADDR_OPTION, 32'h08);
		r0 = resets;
		wdt_run <= 1'b1;
		repeat (40) begin
			@(posedge pclk) clear_watchdog_instr <= 1'b1;
			@(posedge pclk) clear_watchdog_instr <= 1'b0;
		end
		chk(32'(resets), 32'(r0), "cleared watchdog quiet");
		waitc(1'b1, 200, n);
		wdt_run <= 1'b0;
		chk(32'(n < 200), 32'h1, "watchdog reset in run");
		rdchk(`WSC_ADDR_STATUS, st(1'b0, 1'b1), "time-out flag");
		rdchk(`WSC_ADDR_OPTION, 32'hff, "option after device reset");
		// Pending enabled flag turns sleep into a no-op
		src = $urandom_range(10, 2);
		apb(1'b1, `WSC_ADDR_IRQ_CTRL, 32'h1 << src);
		pirq(src);
		pulse_sleep;
		chk({30'h0, io_hold, prefetch_next}, 32'h0, "no-op sleep");
		rdchk(`WSC_ADDR_STATUS, st(1'b0, 1'b1), "no-op sleep flags");
		apb(1'b1, `WSC_ADDR_IRQ_FLAGS, 32'h7ff);
		rdchk(`WSC_ADDR_IRQ_FLAGS, 32'h0, "flags cleared");
		apb(1'b1, `WSC_ADDR_OPTION, 32'h08);
		pulse_sleep;
		chk({29'h0, io_hold, main_osc_enable, prefetch_next}, 32'h5, "sleep entry");
		rdchk(`WSC_ADDR_STATUS, st(1'b1, 1'b0), "sleep flags");
		r0 = resets;
		wdt_run <= 1'b1;
		waitc(1'b0, 200, n);
		wdt_run <= 1'b0;
		chk({31'h0, n < 200 && resets == r0}, 32'h1, "watchdog wake");
		rdchk(`WSC_ADDR_STATUS, st(1'b0, 1'b0), "wake flags");
		chk({30'h0, timeout_flag, powerdown_flag}, 32'h0, "flag pins after wake");
		// Interrupt wake with global enable off and on
		for (int g = 0; g < 2; g++) begin
			apb(1'b1, `WSC_ADDR_IRQ_CTRL, (32'(g) << 15) | (32'h1 << src) | 32'h1);
			pulse_sleep;
			r0 = resumes;
			pirq(0);
			pirq(src == 10 ? 2 : src + 1);
			repeat (10) @(posedge pclk);
			chk(32'(resumes), 32'(r0), "no wake from clocked or masked");
			pirq(src);
			waitc(1'b0, 20, n);
			chk(32'(n <= 8), 32'h1, "rc wake is prompt");
			chk({31'h0, last_branch}, 32'(g), "vector after wake");
			@(negedge pclk);
			chk({31'h0, irq_vector_req}, 32'(g), "vector request");
			apb(1'b1, `WSC_ADDR_IRQ_FLAGS, 32'h7ff);
		end
		// Watchdog disabled, crystal mode
		do_reset(8'h00);
		apb(1'b1, `WSC_ADDR_OPTION, 32'h08);
		apb(1'b1, `WSC_ADDR_IRQ_CTRL, 32'h1 << src);
		r0 = resets;
		wdt_run <= 1'b1;
		repeat (300) @(posedge pclk);
		chk(32'(resets), 32'(r0), "disabled watchdog no reset");
		pulse_sleep;
		r0 = resumes;
		repeat (300) @(posedge pclk);
		chk(32'(resumes), 32'(r0), "disabled watchdog no wake");
		wdt_run <= 1'b0;
		pirq(src);
		waitc(1'b0, 1100, n);
		chk(32'(n >= 1020 && n <= 1040), 32'h1, "start-up delay");
		apb(1'b1, `WSC_ADDR_IRQ_FLAGS, 32'h7ff);
		pulse_sleep;
		r0 = resets;
		@(posedge pclk) external_reset_pin_n <= 1'b0;
		@(posedge pclk) external_reset_pin_n <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(32'(resets > r0), 32'h1, "pin reset in sleep");
		end_sim;
	end

	// Hang guard, far beyond the few thousand cycles the scenarios take
	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		end_sim;
	end
endmodule
`default_nettype wire
